// file: logic/boundary_scan_tap.sv
// boundary-scan test access port: tap controller, instruction, bypass and id registers, pin control
module boundary_scan_tap
	import scan_tap_pkg::*;
#(
	parameter int PIN_COUNT = 8,
	// arbitrary identity values, not those of any real part
	parameter logic [3:0] ID_VERSION = 4'h3,
	parameter logic [15:0] ID_PART = 16'h1234,
	parameter logic [10:0] ID_MAKER = 11'h055
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_bus_active,
	input wire logic [PIN_COUNT-1:0] i_core_out,
	input wire logic [PIN_COUNT-1:0] i_core_oe,
	input wire logic [PIN_COUNT-1:0] i_pin_in,
	input wire logic i_int_scan_tdo,
	input wire logic i_memory_selftest_tdo,
	output logic o_tdo,
	output logic o_tdo_oe,
	output logic [PIN_COUNT-1:0] o_pin_out,
	output logic [PIN_COUNT-1:0] o_pin_oe,
	output logic [PIN_COUNT-1:0] o_core_in,
	output logic o_scan_tdi,
	output logic o_scan_capture,
	output logic o_scan_shift,
	output logic o_scan_update,
	output logic o_int_scan_select,
	output logic o_memory_selftest_select
);

	// two cells per pin: one for the level, one for the driver enable
	localparam int CELL_COUNT = PIN_COUNT * CELLS_PER_PIN;

	// bit 0 stays high so a tester can tell an id from the zero that bypass captures
	localparam logic [ID_WIDTH-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_VALUE};

	// all port state except the boundary cells, synchronisers included, is one register
	typedef struct packed {
		logic [SYNC_DEPTH-1:0] tck_sync;
		logic [SYNC_DEPTH-1:0] tms_sync;
		logic [SYNC_DEPTH-1:0] tdi_sync;
		logic [SYNC_DEPTH-1:0] busy_sync;
		logic [PIN_COUNT-1:0] pin_sync1;
		logic [PIN_COUNT-1:0] pin_sync2;
		logic tck_prev;
		tap_state_type state;
		logic [IR_WIDTH-1:0] ir_shift;
		logic [IR_WIDTH-1:0] ir;
		logic bypass;
		logic [ID_WIDTH-1:0] id_shift;
		logic tdo;
		logic tdo_oe;
		logic [PIN_COUNT-1:0] pin_out;
		logic [PIN_COUNT-1:0] pin_oe;
		logic [PIN_COUNT-1:0] core_in;
		logic scan_tdi;
		logic scan_capture;
		logic scan_shift;
		logic scan_update;
		logic int_scan_sel;
		logic mst_sel;
	} tap_regs_type;

	tap_regs_type st_ff;
	tap_regs_type nxt_st;

	// test clock edges as seen by the reference clock
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;

	// instruction decode
	logic sel_bsr;
	logic sel_id;
	logic sel_int;
	logic sel_mst;
	logic mode_drive;
	logic mode_float;

	// data register strobes and serial paths
	logic dr_capture;
	logic dr_shift;
	logic dr_update;
	logic bsr_so;
	logic dr_so;
	logic [CELL_COUNT-1:0] cap_data;
	logic [CELL_COUNT-1:0] upd_data;
	logic [PIN_COUNT-1:0] drv_out;
	logic [PIN_COUNT-1:0] drv_oe;

	// next state of the sixteen-state controller
	// five rises with tms high reach test-logic-reset from any state
	function automatic tap_state_type tap_next(input tap_state_type cur, input logic tms);
		tap_state_type nxt;
		nxt = cur;
		case (cur)
			TEST_LOGIC_RESET: nxt = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE: nxt = tms ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_DR: nxt = tms ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: nxt = tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: nxt = tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: nxt = tms ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: nxt = tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: nxt = tms ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: nxt = tms ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_IR: nxt = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR: nxt = tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: nxt = tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: nxt = tms ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: nxt = tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: nxt = tms ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: nxt = tms ? SELECT_DR : RUN_TEST_IDLE;
			default: nxt = TEST_LOGIC_RESET;
		endcase
		return nxt;
	endfunction : tap_next

	// a busy bus drops edges instead of resetting the controller, so a scan resumes where it stopped
	// tck is only seen through the reference clock, so it must stay well below half its rate
	assign tck_rise = st_ff.tck_sync[1] & ~st_ff.tck_prev & ~st_ff.busy_sync[1];
	assign tck_fall = ~st_ff.tck_sync[1] & st_ff.tck_prev & ~st_ff.busy_sync[1];
	assign tms_s = st_ff.tms_sync[1];
	assign tdi_s = st_ff.tdi_sync[1];

	// anything not decoded below falls through to the bypass stage
	assign sel_bsr = (st_ff.ir == OP_EXTEST) || (st_ff.ir == OP_SAMPLE);
	assign sel_id = (st_ff.ir == OP_IDCODE);
	assign sel_int = (st_ff.ir == OP_INT_SCAN);
	assign sel_mst = (st_ff.ir == OP_MEM_SELFTEST);
	assign mode_drive = (st_ff.ir == OP_EXTEST) || (st_ff.ir == OP_CLAMP);
	assign mode_float = (st_ff.ir == OP_HIGHZ);

	// capture and shift follow the rising edge, update the falling edge
	assign dr_capture = tck_rise && (st_ff.state == CAPTURE_DR);
	assign dr_shift = tck_rise && (st_ff.state == SHIFT_DR);
	assign dr_update = tck_fall && (st_ff.state == UPDATE_DR);

	always_comb begin
		dr_so = st_ff.bypass;
		if (sel_bsr) begin
			dr_so = bsr_so;
		end else if (sel_id) begin
			dr_so = st_ff.id_shift[0];
		end else if (sel_int) begin
			dr_so = i_int_scan_tdo;
		end else if (sel_mst) begin
			dr_so = i_memory_selftest_tdo;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			// data cell sees the pin, enable cell sees the core's driver enable
			assign cap_data[gi*CELLS_PER_PIN + CELL_DATA] = st_ff.pin_sync2[gi];
			assign cap_data[gi*CELLS_PER_PIN + CELL_ENABLE] = i_core_oe[gi];
			assign drv_out[gi] = mode_drive ? upd_data[gi*CELLS_PER_PIN + CELL_DATA] : i_core_out[gi];
			assign drv_oe[gi] = mode_float ? 1'b0 :
				(mode_drive ? upd_data[gi*CELLS_PER_PIN + CELL_ENABLE] : i_core_oe[gi]);
		end
	endgenerate

	// the cells only see strobes while a boundary instruction is current
	boundary_cell_chain #(
		.CELL_COUNT(CELL_COUNT)
	) u_cells (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_capture(dr_capture && sel_bsr),
		.i_shift(dr_shift && sel_bsr),
		.i_update(dr_update && sel_bsr),
		.i_tdi(tdi_s),
		.i_capture_data(cap_data),
		.o_serial_out(bsr_so),
		.o_update_data(upd_data)
	);

	always_comb begin
		nxt_st = st_ff;

		// each pin-side input passes two stages before anything reads it
		nxt_st.tck_sync = {st_ff.tck_sync[0], i_tck};
		nxt_st.tms_sync = {st_ff.tms_sync[0], i_tms};
		nxt_st.tdi_sync = {st_ff.tdi_sync[0], i_tdi};
		nxt_st.busy_sync = {st_ff.busy_sync[0], i_bus_active};
		nxt_st.pin_sync1 = i_pin_in;
		nxt_st.pin_sync2 = st_ff.pin_sync1;
		nxt_st.tck_prev = st_ff.tck_sync[1];

		// chain strobes are one-cycle pulses, cleared unless an edge sets them
		nxt_st.scan_capture = 1'b0;
		nxt_st.scan_shift = 1'b0;
		nxt_st.scan_update = 1'b0;

		if (tck_rise) begin
			nxt_st.state = tap_next(st_ff.state, tms_s);
			case (st_ff.state)
				CAPTURE_IR: begin
					nxt_st.ir_shift = IR_CAPTURE_VALUE;
				end
				SHIFT_IR: begin
					nxt_st.ir_shift = {tdi_s, st_ff.ir_shift[IR_WIDTH-1:1]};
				end
				CAPTURE_DR: begin
					nxt_st.bypass = 1'b0;
					nxt_st.id_shift = ID_VALUE;
					nxt_st.scan_capture = sel_int || sel_mst;
				end
				SHIFT_DR: begin
					nxt_st.bypass = tdi_s;
					nxt_st.id_shift = {tdi_s, st_ff.id_shift[ID_WIDTH-1:1]};
					nxt_st.scan_shift = sel_int || sel_mst;
					nxt_st.scan_tdi = tdi_s;
				end
				default: begin
				end
			endcase
		end

		// instruction and update stages move on the fall, so decode is settled at the next rise
		if (tck_fall) begin
			case (st_ff.state)
				TEST_LOGIC_RESET: begin
					nxt_st.ir = IR_RESET_VALUE;
				end
				UPDATE_IR: begin
					nxt_st.ir = st_ff.ir_shift;
				end
				UPDATE_DR: begin
					nxt_st.scan_update = sel_int || sel_mst;
				end
				default: begin
				end
			endcase
			// tdo moves only on the falling edge so the tester samples a settled bit
			nxt_st.tdo_oe = (st_ff.state == SHIFT_DR) || (st_ff.state == SHIFT_IR);
			if (st_ff.state == SHIFT_IR) begin
				nxt_st.tdo = st_ff.ir_shift[0];
			end else if (st_ff.state == SHIFT_DR) begin
				nxt_st.tdo = dr_so;
			end
		end

		// a running bus cycle takes tdo off the wire as well
		if (st_ff.busy_sync[1]) begin
			nxt_st.tdo_oe = 1'b0;
		end

		nxt_st.int_scan_sel = sel_int;
		nxt_st.mst_sel = sel_mst;
		nxt_st.pin_out = drv_out;
		nxt_st.pin_oe = drv_oe;
		// sample never touches the pins, only the captured copy
		nxt_st.core_in = st_ff.pin_sync2;
	end

	// power-on reset is the port's own: the controller wakes in test-logic-reset
	// holding the id instruction, whatever the rest of the device is doing
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
			st_ff.state <= TEST_LOGIC_RESET;
			st_ff.ir <= IR_RESET_VALUE;
			st_ff.ir_shift <= IR_CAPTURE_VALUE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// every output is a plain register copy
	assign o_tdo = st_ff.tdo;
	assign o_tdo_oe = st_ff.tdo_oe;
	assign o_pin_out = st_ff.pin_out;
	assign o_pin_oe = st_ff.pin_oe;
	assign o_core_in = st_ff.core_in;
	assign o_scan_tdi = st_ff.scan_tdi;
	assign o_scan_capture = st_ff.scan_capture;
	assign o_scan_shift = st_ff.scan_shift;
	assign o_scan_update = st_ff.scan_update;
	assign o_int_scan_select = st_ff.int_scan_sel;
	assign o_memory_selftest_select = st_ff.mst_sel;

endmodule : boundary_scan_tap

// file: logic/scan_tap_pkg.sv
// shared constants and types of the boundary-scan test access port
package scan_tap_pkg;

	localparam int IR_WIDTH = 5;
	localparam int ID_WIDTH = 32;
	localparam int SYNC_DEPTH = 2;
	localparam int CELLS_PER_PIN = 2;

	localparam logic [IR_WIDTH-1:0] OP_EXTEST = 5'h00;
	localparam logic [IR_WIDTH-1:0] OP_SAMPLE = 5'h01;
	localparam logic [IR_WIDTH-1:0] OP_INT_SCAN = 5'h02;
	localparam logic [IR_WIDTH-1:0] OP_CLAMP = 5'h04;
	localparam logic [IR_WIDTH-1:0] OP_HIGHZ = 5'h05;
	localparam logic [IR_WIDTH-1:0] OP_MEM_SELFTEST = 5'h0A;
	localparam logic [IR_WIDTH-1:0] OP_IDCODE = 5'h0C;
	localparam logic [IR_WIDTH-1:0] OP_BYPASS = 5'h1F;

	localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE = OP_IDCODE;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 5'h01;

	localparam int ID_VERSION_MSB = 31;
	localparam int ID_VERSION_LSB = 28;
	localparam int ID_PART_MSB = 27;
	localparam int ID_PART_LSB = 12;
	localparam int ID_MAKER_MSB = 11;
	localparam int ID_MAKER_LSB = 1;
	localparam int ID_FIXED_BIT = 0;
	localparam logic ID_FIXED_VALUE = 1'h1;

	// cell order inside one pin's pair of boundary cells
	localparam int CELL_DATA = 0;
	localparam int CELL_ENABLE = 1;

	typedef enum logic [3:0] {
		TEST_LOGIC_RESET,
		RUN_TEST_IDLE,
		SELECT_DR,
		CAPTURE_DR,
		SHIFT_DR,
		EXIT1_DR,
		PAUSE_DR,
		EXIT2_DR,
		UPDATE_DR,
		SELECT_IR,
		CAPTURE_IR,
		SHIFT_IR,
		EXIT1_IR,
		PAUSE_IR,
		EXIT2_IR,
		UPDATE_IR
	} tap_state_type;

endpackage : scan_tap_pkg

// file: logic/boundary_cell_chain.sv
// serial boundary-scan cell chain with parallel capture and update stages
module boundary_cell_chain
	import scan_tap_pkg::*;
#(
	parameter int CELL_COUNT = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_capture,
	input wire logic i_shift,
	input wire logic i_update,
	input wire logic i_tdi,
	input wire logic [CELL_COUNT-1:0] i_capture_data,
	output logic o_serial_out,
	output logic [CELL_COUNT-1:0] o_update_data
);

	typedef struct packed {
		logic [CELL_COUNT-1:0] shift_cells;
		logic [CELL_COUNT-1:0] update_cells;
	} chain_regs_type;

	chain_regs_type st_ff;
	chain_regs_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (i_capture) begin
			nxt_st.shift_cells = i_capture_data;
		end else if (i_shift) begin
			// cell 0 sits next to the serial output, tdi enters at the top
			nxt_st.shift_cells = {i_tdi, st_ff.shift_cells[CELL_COUNT-1:1]};
		end
		if (i_update) begin
			nxt_st.update_cells = st_ff.shift_cells;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_serial_out = st_ff.shift_cells[0];
	assign o_update_data = st_ff.update_cells;

endmodule : boundary_cell_chain

// file: verif/scan_tap_props.sv
// checker of the tap port timing relations
module scan_tap_props #(
	parameter int PIN_COUNT = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_tck,
	input wire logic i_bus_active,
	input wire logic i_tdi,
	input wire logic o_scan_tdi,
	input wire logic o_scan_update,
	input wire logic [PIN_COUNT-1:0] i_pin_in,
	input wire logic o_tdo,
	input wire logic o_tdo_oe,
	input wire logic [PIN_COUNT-1:0] o_pin_oe,
	input wire logic [PIN_COUNT-1:0] o_core_in,
	input wire logic o_scan_capture,
	input wire logic o_scan_shift,
	input wire logic o_int_scan_select,
	input wire logic o_memory_selftest_select
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);
	// four cycles covers the two sync stages and the output register
	sequence bus_held;
		i_bus_active [*4];
	endsequence
	sequence after_fall;
		!$past(i_tck, 2);
	endsequence
	bus_quiet_a: assert property (bus_held |-> !o_tdo_oe)
		else $error("tdo driven while bus busy");
	tdo_edge_a: assert property (!$stable(o_tdo) |-> after_fall)
		else $error("tdo moved away from a tck fall");
	oe_edge_a: assert property (!$stable(o_tdo_oe) |-> after_fall)
		else $error("tdo enable moved away from a tck fall");
	select_excl_a: assert property (!(o_int_scan_select && o_memory_selftest_select))
		else $error("both chains selected");
	shift_sel_a: assert property (o_scan_shift |-> o_int_scan_select || o_memory_selftest_select)
		else $error("chain shift without selection");
	update_sel_a: assert property (o_scan_update |-> o_int_scan_select || o_memory_selftest_select)
		else $error("chain update without selection");
	scan_tdi_a: assert property (o_scan_shift |-> o_scan_tdi == $past(i_tdi, 3))
		else $error("chain tdi not the sampled tdi");
	capture_pulse_a: assert property (o_scan_capture |=> !o_scan_capture)
		else $error("capture pulse too long");
	core_follow_a: assert property ($stable(i_pin_in) [*5] |-> o_core_in == i_pin_in)
		else $error("core input lost the pins");
	reset_quiet_a: assert property ($rose(i_arst_n) |-> !o_tdo_oe && o_pin_oe == '0)
		else $error("pins driven in reset");
endmodule : scan_tap_props

bind boundary_scan_tap scan_tap_props #(.PIN_COUNT(PIN_COUNT)) scan_tap_props_i (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_tck(i_tck), .i_bus_active(i_bus_active),
	.i_tdi(i_tdi), .o_scan_tdi(o_scan_tdi), .o_scan_update(o_scan_update),
	.i_pin_in(i_pin_in), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_pin_oe(o_pin_oe), .o_core_in(o_core_in),
	.o_scan_capture(o_scan_capture), .o_scan_shift(o_scan_shift), .o_int_scan_select(o_int_scan_select),
	.o_memory_selftest_select(o_memory_selftest_select));

// file: verif/scan_tester.sv
// board tester model driving the test port pins
module scan_tester (
	input wire logic i_ref_clk,
	input wire logic i_tdo,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// one 320 ns period; tck rests low between calls, tdo read late in the high phase
	task automatic pulse(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		repeat (4) @(negedge i_ref_clk);
		o_tck = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		tdo = i_tdo;
		o_tck = 1'b0;
	endtask : pulse
	// from run-test-idle through one scan and back, lsb first
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic b;
		dout = '0;
		pulse(1'b1, 1'b0, b);
		if (ir)
			pulse(1'b1, 1'b0, b);
		pulse(1'b0, 1'b0, b);
		pulse(1'b0, 1'b0, b);
		for (int k = 0; k < n; k++) begin
			pulse(k == n - 1, din[k], b);
			dout[k] = b;
		end
		pulse(1'b1, 1'b0, b);
		pulse(1'b0, 1'b0, b);
	endtask : scan
	task automatic reset_tap();
		logic b;
		repeat (5) pulse(1'b1, 1'b0, b);
		pulse(1'b0, 1'b0, b);
	endtask : reset_tap
endmodule : scan_tester

// file: verif/boundary_scan_tap_bench.sv
// self-checking bench of the boundary-scan tap
module boundary_scan_tap_bench;
	import scan_tap_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PINS = 8;
	// identity fields are arbitrary
	localparam logic [31:0] ID_EXP = {4'h6, 16'hA5C3, 11'h2B4, ID_FIXED_VALUE};
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic bus_active = 1'b0;
	logic [PINS-1:0] core_out = '0, core_oe = '0, pin_in = '0;
	logic chain_tdo = 1'b0, mem_tdo = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe, tdo_wire, int_sel, mem_sel;
	logic [PINS-1:0] pin_out, pin_oe, core_in;
	logic [4:0] ops [10] = '{OP_EXTEST, OP_SAMPLE, OP_CLAMP, OP_HIGHZ, OP_INT_SCAN, OP_MEM_SELFTEST,
		OP_IDCODE, OP_BYPASS, 5'h03, 5'h1E};
	logic [31:0] got, din;
	logic [15:0] upd = '0;
	int error_cnt = 0, checked = 0, seed = 32'h4E8B1E9B;

	always #20 i_ref_clk = ~i_ref_clk;
	// a released tdo shows the opposite of its last level
	assign tdo_wire = tdo_oe ? tdo : ~tdo;

	boundary_scan_tap #(.PIN_COUNT(PINS), .ID_VERSION(ID_EXP[31:28]), .ID_PART(ID_EXP[27:12]),
		.ID_MAKER(ID_EXP[11:1])) boundary_scan_tap_i (
		.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_bus_active(bus_active), .i_core_out(core_out), .i_core_oe(core_oe), .i_pin_in(pin_in),
		.i_int_scan_tdo(chain_tdo), .i_memory_selftest_tdo(mem_tdo), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_core_in(core_in), .o_scan_tdi(), .o_scan_capture(),
		.o_scan_shift(), .o_scan_update(), .o_int_scan_select(int_sel), .o_memory_selftest_select(mem_sel));
	scan_tester scan_tester_i (.i_ref_clk(i_ref_clk), .i_tdo(tdo_wire), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// pin level in even cells, core enable in odd cells
	function automatic logic [15:0] dr_exp(input logic [4:0] op, input logic [15:0] d);
		for (int p = 0; p < PINS; p++)
			{dr_exp[2*p+1], dr_exp[2*p]} = {core_oe[p], pin_in[p]};
		case (op)
			OP_EXTEST, OP_SAMPLE: ;
			OP_IDCODE: dr_exp = ID_EXP[15:0];
			OP_INT_SCAN: dr_exp = {16{chain_tdo}};
			OP_MEM_SELFTEST: dr_exp = {16{mem_tdo}};
			default: dr_exp = {d[14:0], 1'b0};
		endcase
	endfunction : dr_exp
	function automatic logic [15:0] pin_exp(input logic [4:0] op);
		pin_exp = {core_oe, core_out};
		if (op == OP_HIGHZ)
			pin_exp = 16'h0000;
		if (op inside {OP_EXTEST, OP_CLAMP})
			for (int p = 0; p < PINS; p++)
				{pin_exp[PINS+p], pin_exp[p]} = {upd[2*p+1], upd[2*p]};
	endfunction : pin_exp

	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		// the controller wakes in test-logic-reset: one low tms rise reaches run-test-idle
		scan_tester_i.pulse(1'b0, 1'b0, got[0]);
		scan_tester_i.scan(1'b0, 32, $random(seed), got);
		check(got, ID_EXP);
		$display("power-on id done");
		foreach (ops[j]) begin
			{pin_in, core_out, core_oe} = 24'($random(seed));
			chain_tdo = 1'($random(seed));
			mem_tdo = ~chain_tdo;
			din = $random(seed);
			scan_tester_i.scan(1'b1, 5, {27'h0, ops[j]}, got);
			check(got, {27'h0, IR_CAPTURE_VALUE});
			scan_tester_i.scan(1'b0, 16, din, got);
			check(got, dr_exp(ops[j], din[15:0]));
			if (ops[j] inside {OP_EXTEST, OP_SAMPLE})
				upd = din[15:0];
			repeat (4) @(negedge i_ref_clk);
			check({pin_oe, (ops[j] == OP_HIGHZ) ? 8'h00 : pin_out}, pin_exp(ops[j]));
			check({int_sel, mem_sel}, {ops[j] == OP_INT_SCAN, ops[j] == OP_MEM_SELFTEST});
			check(core_in, pin_in);
			$display("code %h done", ops[j]);
		end
		// tester misuses the port during bus cycles: all of it must be dropped
		bus_active = 1'b1;
		scan_tester_i.reset_tap();
		scan_tester_i.scan(1'b0, 16, din, got);
		bus_active = 1'b0;
		repeat (4) @(negedge i_ref_clk);
		scan_tester_i.scan(1'b0, 16, din, got);
		check(got, {din[14:0], 1'b0});
		// power-on reset in mid-run must bring back the id instruction
		scan_tester_i.scan(1'b1, 5, {27'h0, OP_BYPASS}, got);
		check(got, {27'h0, IR_CAPTURE_VALUE});
		i_arst_n = 1'b0;
		repeat (2) @(negedge i_ref_clk);
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		scan_tester_i.pulse(1'b0, 1'b0, got[0]);
		scan_tester_i.scan(1'b0, 32, din, got);
		check(got, ID_EXP);
		$display("mid-run reset test done");
		scan_tester_i.reset_tap();
		scan_tester_i.scan(1'b0, 32, din, got);
		check(got, ID_EXP);
		$display("bus and reset tests done");
		final_report();
	end
	initial begin
		#1000000;
		error_cnt++;
		final_report();
	end
endmodule : boundary_scan_tap_bench
